// File: logic/rfm_defines.vh
// shared constants of the read-only code modulator
`ifndef RFM_DEFINES_VH
`define RFM_DEFINES_VH

// ----------------------------------------
// code store and sequence lengths
// ----------------------------------------
`define RFM_CODE_W 128
`define RFM_IDX_W 7
`define RFM_HDR_W 8
`define RFM_LEN_128 2'h0
`define RFM_LEN_96 2'h1
`define RFM_LEN_64 2'h2
`define RFM_LEN_32 2'h3
`define RFM_LAST_128 7'h7f
`define RFM_LAST_96 7'h5f
`define RFM_LAST_64 7'h3f
`define RFM_LAST_32 7'h1f
`define RFM_IDX_ZERO 7'h00
`define RFM_IDX_ONE 7'h01

// ----------------------------------------
// bitrate selection, bit period in rf cycles
// ----------------------------------------
`define RFM_RATE_8 4'h0
`define RFM_RATE_16 4'h1
`define RFM_RATE_32 4'h2
`define RFM_RATE_40 4'h3
`define RFM_RATE_50 4'h4
`define RFM_RATE_64 4'h5
`define RFM_RATE_80 4'h6
`define RFM_RATE_100 4'h7
`define RFM_RATE_128 4'h8
`define RFM_PER_W 8
`define RFM_PER_8 8'h08
`define RFM_PER_16 8'h10
`define RFM_PER_32 8'h20
`define RFM_PER_40 8'h28
`define RFM_PER_50 8'h32
`define RFM_PER_64 8'h40
`define RFM_PER_80 8'h50
`define RFM_PER_100 8'h64
`define RFM_PER_128 8'h80
`define RFM_CNT_ONE 8'h01

// ----------------------------------------
// carrier_freq cycles per bit in phase-shift mode
// ----------------------------------------
`define RFM_CF_4 2'h0
`define RFM_CF_8 2'h1
`define RFM_CF_16 2'h2
`define RFM_CF_32 2'h3

// ----------------------------------------
// frequency-shift half periods (rf/10 and rf/8)
// ----------------------------------------
`define RFM_FSK_HALF_ONE 8'h05
`define RFM_FSK_HALF_ZERO 8'h04

// ----------------------------------------
// modulation selection
// ----------------------------------------
`define RFM_MOD_FSK 3'h0
`define RFM_MOD_PSK 3'h1
`define RFM_MOD_BIT_EDGE_CODE 3'h2
`define RFM_MOD_MANCH 3'h3
`define RFM_MOD_BEC_FSK 3'h4

// ----------------------------------------
// load options
// ----------------------------------------
`define RFM_LOAD_SINGLE 2'h0
`define RFM_LOAD_DOUBLE 2'h1
`define RFM_LOAD_ALT 2'h2

// ----------------------------------------
// arbitrary neutral customer header
// ----------------------------------------
`define RFM_HDR_DEFAULT 8'h3c

`endif

// File: logic/rfm_div_cnt.v
// free running period counter with restart and wrap strobe
`timescale 1ns/10ps
`default_nettype none

`include "rfm_defines.vh"

module rfm_div_cnt #(
  parameter W = 8
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire clr_i,
  input wire [W-1:0] period_i,
  output wire [W-1:0] cnt_o,
  output wire wrap_o
);

  reg [W-1:0] cnt_r; // position inside the period

  // wrap on the last count of the period; a period that shrinks below the
  // running count (fsk tone change) wraps at once instead of rolling over
  assign wrap_o = (cnt_r >= (period_i - {{(W-1){1'b0}}, 1'b1}));
  assign cnt_o = cnt_r;

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= {W{1'b0}};
    end else if (clr_i || wrap_o) begin
      cnt_r <= {W{1'b0}};
    end else begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// File: logic/rfm_pair_buf.v
// two-entry valid/ready buffer with flush
`timescale 1ns/10ps
`default_nettype none

module rfm_pair_buf #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire flush_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] slot0_r; // head entry
  reg [WIDTH-1:0] slot1_r; // tail entry
  reg [1:0] fill_r; // entries held, 0 to 2

  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (fill_r != 2'h2);
  assign out_valid_o = (fill_r != 2'h0);
  assign out_data_o = slot0_r;

  // ----------------------------------------
  // storage and fill level
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slot0_r <= {WIDTH{1'b0}};
      slot1_r <= {WIDTH{1'b0}};
      fill_r <= 2'h0;
    end else if (flush_i) begin
      fill_r <= 2'h0;
    end else begin
      // head takes the new word when empty, or when the only word leaves
      if (pop) begin
        slot0_r <= (fill_r == 2'h2) ? slot1_r : in_data_i;
      end else if (push && fill_r == 2'h0) begin
        slot0_r <= in_data_i;
      end
      // tail fills when the head stays occupied
      if (push && ((fill_r == 2'h1 && !pop) || (fill_r == 2'h2 && pop))) begin
        slot1_r <= in_data_i;
      end
      fill_r <= fill_r + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

`default_nettype wire

// File: logic/rfm_code_mod.v
// read-only code sequencer and load modulator, clocked from the rf field
`timescale 1ns/10ps
`default_nettype none

`include "rfm_defines.vh"

// Operation
// RL1: start sending only after field detected
// RL2: repeat code while field stays present
// RL3: last bit followed directly by first
// RL4: serial out, length 128/96/64/32 bits
// RL5: data read from 128-bit fuse array
// RL6: bitrates rf/8 up to rf/128
// RL7: fsk toggles rf/10 for one, rf/8 zero
// RL8: fsk bitrate limited to rf/32..rf/128
// RL9: psk carrier rf/2, one inverts phase
// RL10: bit-edge code one follows bit clock
// RL11: manchester one damping off mid-bit
// RL12: combined bit-edge code then fsk mode
// RL13: modulation method chosen by fuses
// RL14: modulator output switches the damping load
// RL15: single, double or alternate side damping
// RL16: first 8 bits are fixed header
// RL17: psk bit lasts 4/8/16/32 carriers
// RL18: all timing from rf-derived clock counters
module rfm_code_mod #(
  parameter [7:0] CUST_HEADER = `RFM_HDR_DEFAULT, // arbitrary value, mask fixed
  parameter [1:0] LOAD_OPT = `RFM_LOAD_SINGLE // build-time load circuit option
) (
  input wire clk_i, // clock recovered from the rf field
  input wire arst_n_i, // power-up reset
  input wire field_det_i, // rf field present
  input wire [127:0] fuse_code_i, // fuse array, bits 119:0 sent msb first after the header
  input wire [1:0] fuse_len_i, // code length select
  input wire [3:0] fuse_rate_i, // bitrate select
  input wire [2:0] fuse_mod_i, // modulation select
  input wire [1:0] fuse_carrier_freq_i, // psk carriers per bit
  output reg antenna_pad_a_damp_o, // damping load on pad a
  output reg antenna_pad_b_damp_o, // damping load on pad b
  output reg sending_o, // sequence running
  output reg data_bit_o, // bit currently on air
  output reg seq_start_o // pulse at bit 0 of each sequence
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'b001; // no field, load off
  localparam [2:0] ST_PRIME = 3'b010; // wait for the first buffered bit
  localparam [2:0] ST_SEND = 3'b100; // code going out

  reg [2:0] state_r; // sequencer state
  reg [2:0] state_nxt; // its next value

  // ----------------------------------------
  // code fetch side
  // ----------------------------------------
  reg [6:0] idx_r; // index of the next bit to fetch
  reg [6:0] last_idx; // final index for the chosen length
  wire [127:0] code_vec; // header plus identification bits
  wire fetch_bit; // bit at idx_r
  wire fetch_first; // fetched bit opens a sequence
  wire buf_in_ready; // buffer can take a bit
  wire buf_out_valid; // buffer holds a bit
  wire [1:0] buf_out; // {first flag, bit}
  wire fetch_go; // producer active
  wire buf_flush; // drop stale bits when the field goes

  // header replaces the upper eight fuse positions
  assign code_vec = {CUST_HEADER, fuse_code_i[119:0]}; // RL16 RL5
  // inverting a 7-bit index gives 127-index, so bit 0 is the msb
  assign fetch_bit = code_vec[~idx_r];
  assign fetch_first = (idx_r == `RFM_IDX_ZERO);
  assign fetch_go = (state_r != ST_IDLE) && field_det_i;
  assign buf_flush = (state_r == ST_IDLE);

  // length decode
  always @* begin
    case (fuse_len_i) // RL4
      `RFM_LEN_128: last_idx = `RFM_LAST_128;
      `RFM_LEN_96: last_idx = `RFM_LAST_96;
      `RFM_LEN_64: last_idx = `RFM_LAST_64;
      `RFM_LEN_32: last_idx = `RFM_LAST_32;
      default: last_idx = `RFM_LAST_128;
    endcase
  end

  // fetch index walks the code and wraps without a gap
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idx_r <= `RFM_IDX_ZERO;
    end else if (!fetch_go) begin
      idx_r <= `RFM_IDX_ZERO;
    end else if (buf_in_ready) begin
      if (idx_r >= last_idx) begin
        idx_r <= `RFM_IDX_ZERO; // RL3
      end else begin
        idx_r <= idx_r + `RFM_IDX_ONE; // RL4
      end
    end
  end

  // ----------------------------------------
  // bit timing
  // ----------------------------------------
  reg [7:0] bit_per; // bit period in rf cycles
  wire [7:0] bit_cnt; // position inside the bit
  wire bit_wrap; // last cycle of a bit
  wire bit_clr; // hold the bit timer outside sending
  wire is_fsk; // modes built on the fsk carrier
  wire [7:0] bit_half; // cycle count of half a bit

  assign is_fsk = (fuse_mod_i == `RFM_MOD_FSK) || (fuse_mod_i == `RFM_MOD_BEC_FSK);
  assign bit_clr = (state_r != ST_SEND);
  assign bit_half = {1'b0, bit_per[7:1]};

  // period lookup; psk counts carrier cycles of two rf cycles each
  always @* begin
    if (fuse_mod_i == `RFM_MOD_PSK) begin
      case (fuse_carrier_freq_i) // RL17
        `RFM_CF_4: bit_per = `RFM_PER_8;
        `RFM_CF_8: bit_per = `RFM_PER_16;
        `RFM_CF_16: bit_per = `RFM_PER_32;
        `RFM_CF_32: bit_per = `RFM_PER_64;
        default: bit_per = `RFM_PER_8;
      endcase
    end else begin
      case (fuse_rate_i) // RL6
        `RFM_RATE_8: bit_per = `RFM_PER_8;
        `RFM_RATE_16: bit_per = `RFM_PER_16;
        `RFM_RATE_32: bit_per = `RFM_PER_32;
        `RFM_RATE_40: bit_per = `RFM_PER_40;
        `RFM_RATE_50: bit_per = `RFM_PER_50;
        `RFM_RATE_64: bit_per = `RFM_PER_64;
        `RFM_RATE_80: bit_per = `RFM_PER_80;
        `RFM_RATE_100: bit_per = `RFM_PER_100;
        `RFM_RATE_128: bit_per = `RFM_PER_128;
        default: bit_per = `RFM_PER_128;
      endcase
      // fsk cannot fit a useful burst in a short bit, so it is held at rf/32
      if (is_fsk && bit_per < `RFM_PER_32) begin
        bit_per = `RFM_PER_32; // RL8
      end
    end
  end

  // bit clock counter runs on the recovered rf clock
  rfm_div_cnt #(
    .W(`RFM_PER_W)
  ) u_bit_timer (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .clr_i(bit_clr),
    .period_i(bit_per),
    .cnt_o(bit_cnt),
    .wrap_o(bit_wrap)
  ); // RL18

  // ----------------------------------------
  // bit buffer between fetch and modulator
  // ----------------------------------------
  wire bit_load; // modulator takes the next bit
  wire mid_bit; // last cycle of the first half

  assign bit_load = ((state_r == ST_PRIME) && buf_out_valid) ||
                    ((state_r == ST_SEND) && bit_wrap);
  assign mid_bit = (state_r == ST_SEND) && (bit_cnt == (bit_half - `RFM_CNT_ONE));

  rfm_pair_buf #(
    .WIDTH(2)
  ) u_bit_buf (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .flush_i(buf_flush),
    .in_valid_i(fetch_go),
    .in_ready_o(buf_in_ready),
    .in_data_i({fetch_first, fetch_bit}),
    .out_valid_o(buf_out_valid),
    .out_ready_i(bit_load),
    .out_data_o(buf_out)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // nothing is sent before the field is seen
        if (field_det_i) begin
          state_nxt = ST_PRIME; // RL1
        end
      end
      ST_PRIME: begin
        if (!field_det_i) begin
          state_nxt = ST_IDLE;
        end else if (buf_out_valid) begin
          state_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        // stays here for as long as the field lasts
        if (!field_det_i) begin
          state_nxt = ST_IDLE; // RL2
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // modulator state
  // ----------------------------------------
  reg cur_bit_r; // bit being encoded
  reg sec_half_r; // second half of the bit
  reg bec_lvl_r; // bit-edge code level
  reg psk_r; // rf/2 carrier
  reg fsk_r; // fsk square wave
  reg side_r; // pad used by alternate damping
  reg damp_r; // previous damping level
  reg bec_lvl_nxt; // bit-edge code level next
  reg damp_nxt; // encoded damping request
  wire fsk_one; // fsk tone for a one
  wire [7:0] fsk_half; // fsk half period in rf cycles
  wire fsk_wrap; // fsk half period over
  wire send; // modulator active

  // a lost field stops the damping on the very next edge, not one bit later
  assign send = (state_r == ST_SEND) && field_det_i; // RL2
  // combined mode keys the tone from the bit-edge level, not the raw bit
  assign fsk_one = (fuse_mod_i == `RFM_MOD_BEC_FSK) ? bec_lvl_r : cur_bit_r; // RL12
  assign fsk_half = fsk_one ? `RFM_FSK_HALF_ONE : `RFM_FSK_HALF_ZERO; // RL7

  rfm_div_cnt #(
    .W(`RFM_PER_W)
  ) u_fsk_timer (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .clr_i(bit_clr),
    .period_i(fsk_half),
    .cnt_o(),
    .wrap_o(fsk_wrap)
  ); // RL18

  // bit-edge code: toggle at every bit start, again mid-bit for a one
  always @* begin
    bec_lvl_nxt = bec_lvl_r;
    if (bit_load) begin
      bec_lvl_nxt = ~bec_lvl_r;
    end else if (mid_bit && cur_bit_r) begin
      bec_lvl_nxt = ~bec_lvl_r; // RL10
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur_bit_r <= 1'b0;
      sec_half_r <= 1'b0;
      bec_lvl_r <= 1'b0;
      psk_r <= 1'b0;
      fsk_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      cur_bit_r <= 1'b0;
      sec_half_r <= 1'b0;
      bec_lvl_r <= 1'b0;
      psk_r <= 1'b0;
      fsk_r <= 1'b0;
    end else begin
      bec_lvl_r <= bec_lvl_nxt;
      if (bit_load) begin
        cur_bit_r <= buf_out[0];
        sec_half_r <= 1'b0;
      end else if (mid_bit) begin
        sec_half_r <= 1'b1;
      end
      // a one holds the carrier for a cycle at its end: a 180 degree shift
      if (send && !(bit_wrap && cur_bit_r)) begin
        psk_r <= ~psk_r; // RL9
      end
      if (send && fsk_wrap) begin
        fsk_r <= ~fsk_r; // RL7
      end
    end
  end

  // ----------------------------------------
  // encoder select
  // ----------------------------------------
  always @* begin
    damp_nxt = 1'b0;
    if (send) begin
      case (fuse_mod_i) // RL13
        `RFM_MOD_FSK: damp_nxt = fsk_r;
        `RFM_MOD_PSK: damp_nxt = psk_r;
        `RFM_MOD_BIT_EDGE_CODE: damp_nxt = bec_lvl_r;
        // damping on first half of a one, off after mid-bit (falling edge)
        `RFM_MOD_MANCH: damp_nxt = sec_half_r ? ~cur_bit_r : cur_bit_r; // RL11
        `RFM_MOD_BEC_FSK: damp_nxt = fsk_r; // RL12
        default: damp_nxt = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // load drive and status outputs
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      damp_r <= 1'b0;
      side_r <= 1'b0;
      antenna_pad_a_damp_o <= 1'b0;
      antenna_pad_b_damp_o <= 1'b0;
      sending_o <= 1'b0;
      data_bit_o <= 1'b0;
      seq_start_o <= 1'b0;
    end else begin
      damp_r <= damp_nxt;
      // alternate option swaps pads at each new damping pulse
      if (damp_nxt && !damp_r) begin
        side_r <= ~side_r; // RL15
      end
      case (LOAD_OPT) // RL15
        `RFM_LOAD_DOUBLE: begin
          antenna_pad_a_damp_o <= damp_nxt; // RL14
          antenna_pad_b_damp_o <= damp_nxt;
        end
        `RFM_LOAD_ALT: begin
          // side_r flips on this same edge, so use the flipped value
          antenna_pad_a_damp_o <= damp_nxt && (side_r ^ (damp_nxt && !damp_r));
          antenna_pad_b_damp_o <= damp_nxt && !(side_r ^ (damp_nxt && !damp_r));
        end
        default: begin
          antenna_pad_a_damp_o <= damp_nxt; // RL14
          antenna_pad_b_damp_o <= 1'b0;
        end
      endcase
      sending_o <= (state_nxt == ST_SEND);
      if (bit_load) begin
        data_bit_o <= buf_out[0];
      end else if (state_r == ST_IDLE) begin
        data_bit_o <= 1'b0;
      end
      seq_start_o <= bit_load && buf_out[1] && field_det_i;
    end
  end

endmodule

`default_nettype wire

// File: verif/rfm_reader_model.sv
// reader station model: supplies the field and counts damping bursts
`timescale 1ns/10ps
`default_nettype none

module rfm_reader_model (
  input wire logic clk_i, // recovered rf clock
  input wire logic arst_n_i, // power-up reset, active low
  input wire logic field_on_i, // bench switches the carrier on or off
  input wire logic pad_a_i, // damping seen on pad a
  input wire logic pad_b_i, // damping seen on pad b
  output logic field_det_o, // field present at the tag
  output logic [15:0] edges_o // count of damping onsets seen by the reader
);
  // ----------------------------------------
  // field and load sensing
  // ----------------------------------------
  logic load_r; // last sensed load, either pad counts

  // field follows the request directly, the tag sees it at once
  assign field_det_o = field_on_i;

  // a rising load is one detectable damping change
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      load_r <= 1'b0;
      edges_o <= 16'h0000;
    end else begin
      load_r <= pad_a_i | pad_b_i;
      if ((pad_a_i | pad_b_i) && !load_r) begin
        edges_o <= edges_o + 16'h0001;
      end
    end
  end
endmodule

`default_nettype wire

// File: verif/rfm_code_mon_monitor.sv
// port assertions for the code modulator
`timescale 1ns/10ps
`default_nettype none

`include "rfm_defines.vh"

module rfm_code_mon #(
  parameter [7:0] CUST_HEADER = `RFM_HDR_DEFAULT,
  parameter [1:0] LOAD_OPT = `RFM_LOAD_SINGLE
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic field_det_i,
  input wire logic [127:0] fuse_code_i,
  input wire logic [1:0] fuse_len_i,
  input wire logic [3:0] fuse_rate_i,
  input wire logic [2:0] fuse_mod_i,
  input wire logic [1:0] fuse_carrier_freq_i,
  input wire logic antenna_pad_a_damp_o,
  input wire logic antenna_pad_b_damp_o,
  input wire logic sending_o,
  input wire logic data_bit_o,
  input wire logic seq_start_o
);
  // ----------------------------------------
  // bit phase tracking
  // ----------------------------------------
  logic [7:0] per; // bit period in clocks
  logic [15:0] seq_len; // whole sequence in clocks
  logic [7:0] ph; // clock index inside the bit
  logic [7:0] ph_r;
  logic [6:0] idx; // bit index inside the sequence
  logic [6:0] idx_r;
  logic [15:0] gap_r; // clocks since the last sequence start
  logic seen_r; // one sequence start seen in this field session
  logic exp_bit; // bit that should be on air

  // period table; fsk clamps fast rates, psk counts carriers
  always_comb begin
    case (fuse_rate_i)
      `RFM_RATE_8: per = `RFM_PER_8;
      `RFM_RATE_16: per = `RFM_PER_16;
      `RFM_RATE_32: per = `RFM_PER_32;
      `RFM_RATE_40: per = `RFM_PER_40;
      `RFM_RATE_50: per = `RFM_PER_50;
      `RFM_RATE_64: per = `RFM_PER_64;
      `RFM_RATE_80: per = `RFM_PER_80;
      `RFM_RATE_100: per = `RFM_PER_100;
      default: per = `RFM_PER_128;
    endcase
    if ((fuse_mod_i == `RFM_MOD_FSK || fuse_mod_i == `RFM_MOD_BEC_FSK) && per < `RFM_PER_32) begin
      per = `RFM_PER_32;
    end
    if (fuse_mod_i == `RFM_MOD_PSK) begin
      per = 8'h08 << fuse_carrier_freq_i;
    end
    seq_len = {8'h00, per} * (16'h0080 - ({14'h0000, fuse_len_i} << 5));
    ph = seq_start_o ? 8'h00 : ph_r;
    idx = seq_start_o ? 7'h00 : idx_r;
    exp_bit = (idx < 7'h08) ? CUST_HEADER[3'h7 - idx[2:0]] : fuse_code_i[7'h7f - idx];
  end

  // counters restart at each sequence start
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ph_r <= 8'h00;
      idx_r <= 7'h00;
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      ph_r <= (ph == per - 8'h01) ? 8'h00 : ph + 8'h01;
      idx_r <= (ph == per - 8'h01) ? idx + 7'h01 : idx;
      gap_r <= seq_start_o ? 16'h0001 : gap_r + 16'h0001;
      seen_r <= sending_o && field_det_i && (seen_r || seq_start_o);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence field_rise_s;
    $rose(field_det_i) ##1 field_det_i [*2];
  endsequence

  start_seq_a: assert property (field_rise_s |=> sending_o && seq_start_o)
    else $error("sequence did not start two clocks after field");
  send_field_a: assert property (sending_o |-> $past(field_det_i))
    else $error("sending without field");
  field_drop_a: assert property (!field_det_i |=> !sending_o && !antenna_pad_a_damp_o && !antenna_pad_b_damp_o)
    else $error("activity after field loss");
  seq_gap_a: assert property (seq_start_o && seen_r |-> gap_r == seq_len)
    else $error("sequence length in clocks wrong");
  bit_value_a: assert property (sending_o && (seen_r || seq_start_o) && ph == 8'h00 |-> data_bit_o == exp_bit)
    else $error("wrong bit on air");
  manch_half_a: assert property (fuse_mod_i == `RFM_MOD_MANCH && LOAD_OPT != `RFM_LOAD_ALT && sending_o
      && field_det_i && (seen_r || seq_start_o)
      |=> antenna_pad_a_damp_o == ($past(data_bit_o) ^ ($past(ph) >= (per >> 1))))
    else $error("manchester half wrong");
  psk_phase_a: assert property ((fuse_mod_i == `RFM_MOD_PSK && LOAD_OPT != `RFM_LOAD_ALT && seen_r && field_det_i)
      ##1 field_det_i
      |=> antenna_pad_a_damp_o == ($past(antenna_pad_a_damp_o) ^ !($past(data_bit_o, 2) && $past(ph, 2) == per - 8'h01)))
    else $error("psk carrier phase wrong");
  bec_edge_a: assert property (fuse_mod_i == `RFM_MOD_BIT_EDGE_CODE && LOAD_OPT != `RFM_LOAD_ALT && seen_r && field_det_i
      |=> $changed(antenna_pad_a_damp_o) == ($past(ph) == 8'h00 || ($past(data_bit_o) && $past(ph) == (per >> 1))))
    else $error("bit edge code transition wrong");
  single_side_a: assert property (LOAD_OPT == `RFM_LOAD_SINGLE |-> !antenna_pad_b_damp_o)
    else $error("pad b damped in single side build");
  alt_side_a: assert property (LOAD_OPT == `RFM_LOAD_ALT |-> !(antenna_pad_a_damp_o && antenna_pad_b_damp_o))
    else $error("both pads damped in alternate build");
endmodule

bind rfm_code_mod rfm_code_mon #(.CUST_HEADER(CUST_HEADER), .LOAD_OPT(LOAD_OPT)) mon_u (
  .clk_i(clk_i),
  .arst_n_i(arst_n_i),
  .field_det_i(field_det_i),
  .fuse_code_i(fuse_code_i),
  .fuse_len_i(fuse_len_i),
  .fuse_rate_i(fuse_rate_i),
  .fuse_mod_i(fuse_mod_i),
  .fuse_carrier_freq_i(fuse_carrier_freq_i),
  .antenna_pad_a_damp_o(antenna_pad_a_damp_o),
  .antenna_pad_b_damp_o(antenna_pad_b_damp_o),
  .sending_o(sending_o),
  .data_bit_o(data_bit_o),
  .seq_start_o(seq_start_o)
);

`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the code modulator
`timescale 1ns/10ps
`default_nettype none

module testbench;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  localparam [7:0] HDR = 8'h96; // arbitrary header value
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic field_on = 1'b0; // carrier request to the reader
  logic field_det;
  logic [127:0] fuse_code = 128'h0123_4567_89ab_cdef_f0e1_d2c3_b4a5_9687;
  logic [1:0] fuse_len = 2'h0;
  logic [3:0] rate = 4'h0;
  logic [2:0] mode = 3'h0;
  logic [1:0] cf = 2'h0;
  logic pad_a, pad_b, sending, data_bit, seq_start;
  logic [15:0] edges; // damping onsets seen by the reader
  int fails = 0;
  int checks = 0;

  always #5 clk_i = ~clk_i;

  rfm_code_mod #(.CUST_HEADER(HDR), .LOAD_OPT(2'h0)) dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .field_det_i(field_det), .fuse_code_i(fuse_code),
    .fuse_len_i(fuse_len), .fuse_rate_i(rate), .fuse_mod_i(mode), .fuse_carrier_freq_i(cf),
    .antenna_pad_a_damp_o(pad_a), .antenna_pad_b_damp_o(pad_b), .sending_o(sending),
    .data_bit_o(data_bit), .seq_start_o(seq_start));

  // alternate-side build on the same fuses, only its pads are watched
  logic alt_a, alt_b;
  logic [1:0] alt_seen = 2'h0; // which alternate pads have damped so far

  rfm_code_mod #(.CUST_HEADER(HDR), .LOAD_OPT(2'h2)) dut_alt_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .field_det_i(field_det), .fuse_code_i(fuse_code),
    .fuse_len_i(fuse_len), .fuse_rate_i(rate), .fuse_mod_i(mode), .fuse_carrier_freq_i(cf),
    .antenna_pad_a_damp_o(alt_a), .antenna_pad_b_damp_o(alt_b), .sending_o(),
    .data_bit_o(), .seq_start_o());

  always @(posedge clk_i) begin
    alt_seen <= alt_seen | {alt_b, alt_a};
  end

  rfm_reader_model reader_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .field_on_i(field_on),
    .pad_a_i(pad_a), .pad_b_i(pad_b), .field_det_o(field_det), .edges_o(edges));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // header first msb first, then fuses from the top
  function automatic logic exp_bit(input int k);
    return (k < 8) ? HDR[7 - k] : fuse_code[127 - k];
  endfunction

  // step n edges, then look once outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // one field session: start latency, one full sequence, wrap, field loss
  task automatic run_case(input logic [2:0] m, input logic [3:0] r, input logic [1:0] ln,
      input logic [1:0] c, input int p, input logic dmp);
    int len;
    logic [15:0] e0;
    len = 128 - 32 * ln;
    @(posedge clk_i);
    mode <= m;
    rate <= r;
    fuse_len <= ln;
    cf <= c;
    tick(4);
    e0 = edges;
    @(posedge clk_i);
    field_on <= 1'b1;
    tick(2);
    check_eq(sending, 1'b0);
    tick(1);
    for (int k = 0; k <= len; k++) begin
      check_eq({sending, seq_start}, {1'b1, k % len == 0});
      check_eq(data_bit, exp_bit(k % len));
      if (k < len) tick(p);
    end
    check_eq(edges != e0, dmp);
    @(posedge clk_i);
    field_on <= 1'b0;
    tick(1);
    check_eq({sending, pad_a, pad_b}, 3'h0);
  endtask

  task automatic report_and_stop;
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    tick(4);
    check_eq({sending, pad_a, pad_b}, 3'h0);
    run_case(3'h0, 4'h0, 2'h3, 2'h0, 32, 1'b1);
    run_case(3'h0, 4'h7, 2'h3, 2'h0, 100, 1'b1);
    run_case(3'h1, 4'h0, 2'h2, 2'h1, 16, 1'b1);
    run_case(3'h1, 4'h0, 2'h3, 2'h0, 8, 1'b1);
    run_case(3'h1, 4'h0, 2'h3, 2'h2, 32, 1'b1);
    run_case(3'h1, 4'h0, 2'h3, 2'h3, 64, 1'b1);
    run_case(3'h2, 4'h1, 2'h1, 2'h0, 16, 1'b1);
    run_case(3'h3, 4'h0, 2'h0, 2'h0, 8, 1'b1);
    run_case(3'h3, 4'h2, 2'h3, 2'h0, 32, 1'b1);
    run_case(3'h3, 4'h3, 2'h3, 2'h0, 40, 1'b1);
    run_case(3'h3, 4'h4, 2'h3, 2'h0, 50, 1'b1);
    run_case(3'h3, 4'h5, 2'h3, 2'h0, 64, 1'b1);
    run_case(3'h3, 4'h6, 2'h3, 2'h0, 80, 1'b1);
    run_case(3'h4, 4'h8, 2'h3, 2'h0, 128, 1'b1);
    run_case(3'h5, 4'h0, 2'h3, 2'h0, 8, 1'b0);
    check_eq(alt_seen, 2'h3);
    report_and_stop;
  end

  // the whole run needs well under a third of this span
  initial begin
    #1_000_000;
    fails++;
    report_and_stop;
  end
endmodule

`default_nettype wire
